// ---- design/iox_pkg.sv ----
// Shared constants and types for the four-bit serial I/O expander and its bus master.
// Assumes a 125 MHz system clock at both ends of the two-wire link.
package iox_pkg;

	localparam int PINS = 4;

	// Fixed seven-bit slave address of the expander.
	localparam logic [6:0] SLAVE_ADDR = 7'h41;

	// Register selection carried in the low two bits of the command byte.
	localparam logic [1:0] SEL_INPUT  = 2'h0;
	localparam logic [1:0] SEL_OUTPUT = 2'h1;
	localparam logic [1:0] SEL_INVERT = 2'h2;
	localparam logic [1:0] SEL_CONFIG = 2'h3;

	// Reset values and the fixed upper bits of the input register.
	localparam logic [7:0] OUTPUT_RST  = 8'hFF;
	localparam logic [7:0] INVERT_RST  = 8'h00;
	localparam logic [7:0] CONFIG_RST  = 8'hFF;
	localparam logic [7:0] POINTER_RST = 8'h00;
	localparam logic [3:0] INPUT_UPPER = 4'hF;

	// Timing.
	localparam int CLK_HZ     = 125000000;
	localparam int CLK_NS     = 8;
	localparam int SCL_HZ     = 400000;
	localparam int QTR_CYC    = CLK_HZ / (4 * SCL_HZ);
	localparam int GLITCH_NS  = 16;
	localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

	// Master register map (byte addresses) and fields.
	localparam logic [3:0] CSR_CMD    = 4'h0;
	localparam logic [3:0] CSR_STAT   = 4'h4;
	localparam int         OP_LSB     = 8;
	localparam int         ACK_BIT    = 10;
	localparam int         BUSY_BIT   = 0;
	localparam int         NACK_BIT   = 1;
	localparam int         RXDATA_LSB = 8;

	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2,
		OP_STOP  = 2'h3
	} iox_op_type;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RECV = 3'b001,
		D_RACK = 3'b011,
		D_SEND = 3'b010,
		D_SACK = 3'b110
	} iox_dev_state_type;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_START = 2'b01,
		M_BITS  = 2'b11,
		M_STOP  = 2'b10
	} iox_mst_state_type;

endpackage

// ---- design/iox_if.sv ----
// Two-wire link between the bus master and the expander.
// Both lines are open drain with pull-ups; the interface resolves the wire levels.
`timescale 1ns/1ps
interface iox_if;
	logic mstSclOut;
	logic mstSclOe;
	logic mstSdaOut;
	logic mstSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic scl;
	logic sda;

	// A line is low only when some driver is enabled and drives low.
	assign scl = !(mstSclOe && !mstSclOut);
	assign sda = !((mstSdaOe && !mstSdaOut) || (devSdaOe && !devSdaOut));

	modport master (output mstSclOut, output mstSclOe, output mstSdaOut, output mstSdaOe,
		input scl, input sda);
	modport device (output devSdaOut, output devSdaOe, input scl, input sda);
endinterface

// ---- design/iox_line_filter.sv ----
// Synchroniser and glitch filter for one incoming link line.
// Assumes the line idles high; output changes only after a stable run.
`timescale 1ns/1ps
module iox_line_filter
	import iox_pkg::*;
#(
	parameter int STABLE_CYC = GLITCH_CYC
)(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic lineRaw,
	output logic      lineClean
);
	logic       sync1_q;
	logic       sync2_q;
	logic [3:0] run_q;
	logic       clean_q;

	// Two flops bring the line into the clock domain.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= lineRaw;
			sync2_q <= sync1_q;
		end
	end

	// A new level is taken only after it held for the stable run, so short spikes vanish.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q   <= 4'h0;
			clean_q <= 1'b1;
		end else if (sync2_q == clean_q) begin
			run_q <= 4'h0;
		end else if (run_q == 4'(STABLE_CYC - 1)) begin
			run_q   <= 4'h0;
			clean_q <= sync2_q;
		end else begin
			run_q <= run_q + 4'h1;
		end
	end

	assign lineClean = clean_q;
endmodule

// ---- design/iox_expander.sv ----
// Four-bit I/O expander: serial slave end of the link and its port registers.
// Assumes a single master on the link that makes the serial clock; no clock stretching.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Input direction turns both pin drivers off.
// - Output direction drives pin from output register.
// - Master starts only on idle bus.
// - Stop returns slave to idle.
// - One bit per clock; high-phase changes are conditions.
// - Address byte sent MSB first, direction last.
// - Respond only to address 0x41.
// - Direction bit one reads, zero writes.
// - Acknowledge matching address by holding data low.
// - Each byte has one acknowledge; unlimited bytes.
// - Transmitter releases data before acknowledge bit.
// - Receiving slave acknowledges every byte.
// - Master acknowledges reads except the last.
// - Missing acknowledge: slave releases and stops sending.
// - First write byte is stored as command.
// - Command low bits select one of four registers.
// - Selection persists until next command byte.
// - Reset loads documented register defaults.
// - Only low four data bits control pins.
// - Config one means input, zero means output.
// - Input register returns pins; writes ignored.
// - Polarity one inverts returned input bit.
// - Output register reads back flops, not pins.
module iox_expander
	import iox_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	iox_if.device                bus,
	input  wire logic [PINS-1:0] portPinIn,
	output logic      [PINS-1:0] portPinOut,
	output logic      [PINS-1:0] portPinOe
);
	logic              sclF;
	logic              sdaF;
	logic              sclPrev_q;
	logic              sdaPrev_q;
	logic              sclRise;
	logic              sclFall;
	logic              startSeen;
	logic              stopSeen;
	logic [PINS-1:0]   pinSync1_q;
	logic [PINS-1:0]   pinSync2_q;
	iox_dev_state_type state_q;
	logic [3:0]        bitCnt_q;
	logic [7:0]        shift_q;
	logic [1:0]        byteIdx_q;
	logic              readMode_q;
	logic              sdaLow_q;
	logic              ackSeen_q;
	logic [7:0]        pointer_q;
	logic [7:0]        outReg_q;
	logic [7:0]        invReg_q;
	logic [7:0]        cfgReg_q;
	logic              byteDone;
	logic              cmdDone;
	logic              dataDone;
	logic [7:0]        readByte;

	// Returns the byte that the selected register presents to the master.
	function automatic logic [7:0] readMux(input logic [1:0] sel, input logic [PINS-1:0] pins,
		input logic [7:0] outR, input logic [7:0] invR, input logic [7:0] cfgR);
		case (sel)
			SEL_INPUT:  readMux = {INPUT_UPPER, pins ^ invR[PINS-1:0]};
			SEL_OUTPUT: readMux = outR;
			SEL_INVERT: readMux = invR;
			default:    readMux = cfgR;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Line conditioning and bus event detection.

	iox_line_filter u_sclFilter (
		.clk       (clk),
		.reset_n   (reset_n),
		.lineRaw   (bus.scl),
		.lineClean (sclF)
	);

	iox_line_filter u_sdaFilter (
		.clk       (clk),
		.reset_n   (reset_n),
		.lineRaw   (bus.sda),
		.lineClean (sdaF)
	);

	// Previous filtered levels for edge detection.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			sclPrev_q <= sclF;
			sdaPrev_q <= sdaF;
		end
	end

	// Both lines share one filter delay, so their order is kept and a data
	// change seen while the clock stays high is a start or stop condition.
	assign sclRise   = sclF && !sclPrev_q;
	assign sclFall   = !sclF && sclPrev_q;
	assign startSeen = sclF && sclPrev_q && sdaPrev_q && !sdaF;
	assign stopSeen  = sclF && sclPrev_q && !sdaPrev_q && sdaF;

	// Pin levels come from outside and pass two flops before use.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pinSync1_q <= '1;
			pinSync2_q <= '1;
		end else begin
			pinSync1_q <= portPinIn;
			pinSync2_q <= pinSync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial state machine.

	assign byteDone = (state_q == D_RECV) && sclFall && (bitCnt_q == 4'h8);
	assign cmdDone  = byteDone && (byteIdx_q == 2'h1);
	assign dataDone = byteDone && (byteIdx_q == 2'h2);
	assign readByte = readMux(pointer_q[1:0], pinSync2_q, outReg_q, invReg_q, cfgReg_q);

	// Stop and start override whatever byte is in flight.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q    <= D_IDLE;
			bitCnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			byteIdx_q  <= 2'h0;
			readMode_q <= 1'b0;
			sdaLow_q   <= 1'b0;
			ackSeen_q  <= 1'b0;
		end else if (stopSeen) begin
			state_q  <= D_IDLE;
			sdaLow_q <= 1'b0;
		end else if (startSeen) begin
			state_q    <= D_RECV;
			bitCnt_q   <= 4'h0;
			byteIdx_q  <= 2'h0;
			readMode_q <= 1'b0;
			sdaLow_q   <= 1'b0;
		end else begin
			case (state_q)
				D_RECV: begin
					if (sclRise && bitCnt_q != 4'h8) begin
						shift_q  <= {shift_q[6:0], sdaF};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (byteDone) begin
						if (byteIdx_q == 2'h0 && shift_q[7:1] != SLAVE_ADDR) begin
							state_q <= D_IDLE;
						end else begin
							state_q  <= D_RACK;
							sdaLow_q <= 1'b1;
							if (byteIdx_q == 2'h0) begin
								readMode_q <= shift_q[0];
							end
							if (byteIdx_q != 2'h2) begin
								byteIdx_q <= byteIdx_q + 2'h1;
							end
						end
					end
				end
				D_RACK: begin
					if (sclFall) begin
						bitCnt_q <= 4'h0;
						if (readMode_q) begin
							state_q  <= D_SEND;
							shift_q  <= readByte;
							sdaLow_q <= !readByte[7];
						end else begin
							state_q  <= D_RECV;
							sdaLow_q <= 1'b0;
						end
					end
				end
				D_SEND: begin
					if (sclFall) begin
						if (bitCnt_q == 4'h7) begin
							state_q  <= D_SACK;
							sdaLow_q <= 1'b0;
						end else begin
							shift_q  <= {shift_q[6:0], 1'b0};
							sdaLow_q <= !shift_q[6];
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
				end
				D_SACK: begin
					if (sclRise) begin
						ackSeen_q <= !sdaF;
					end else if (sclFall) begin
						bitCnt_q <= 4'h0;
						if (ackSeen_q) begin
							state_q  <= D_SEND;
							shift_q  <= readByte;
							sdaLow_q <= !readByte[7];
						end else begin
							state_q <= D_IDLE;
						end
					end
				end
				default: begin
					state_q  <= D_IDLE;
					sdaLow_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port registers.

	// The command byte is kept until the next command byte replaces it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pointer_q <= POINTER_RST;
		end else if (cmdDone) begin
			pointer_q <= shift_q;
		end
	end

	// Data bytes land in the selected register, or are dropped when the input register is selected; repeated bytes overwrite it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			outReg_q <= OUTPUT_RST;
			invReg_q <= INVERT_RST;
			cfgReg_q <= CONFIG_RST;
		end else if (dataDone) begin
			case (pointer_q[1:0])
				SEL_OUTPUT: outReg_q <= shift_q;
				SEL_INVERT: invReg_q <= shift_q;
				SEL_CONFIG: cfgReg_q <= shift_q;
				default:    outReg_q <= outReg_q;
			endcase
		end
	end

	// Upper data bits are stored for readback but never reach a pin.
	assign portPinOe  = ~cfgReg_q[PINS-1:0];
	assign portPinOut = outReg_q[PINS-1:0];

	// The slave only ever pulls the data line low.
	assign bus.devSdaOut = 1'b0;
	assign bus.devSdaOe  = sdaLow_q;
endmodule

// ---- design/iox_master.sv ----
// Byte-level master for the two-wire link, driven by software over Avalon-MM.
// Assumes it is the only master and that the slave never stretches the clock.
`timescale 1ns/1ps
module iox_master
	import iox_pkg::*;
#(
	parameter int QTR = QTR_CYC
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	iox_if.master            bus,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest
);
	logic              sdaF;
	iox_mst_state_type state_q;
	logic [15:0]       qCnt_q;
	logic [1:0]        phase_q;
	logic [3:0]        bitCnt_q;
	logic [8:0]        tx_q;
	logic [8:0]        rx_q;
	logic              sclHigh_q;
	logic              sdaHigh_q;
	logic [7:0]        rxByte_q;
	logic              nack_q;
	logic              rdValid_q;
	logic              tick;
	logic              cmdTake;
	iox_op_type        op;

	iox_line_filter u_sdaFilter (
		.clk       (clk),
		.reset_n   (reset_n),
		.lineRaw   (bus.sda),
		.lineClean (sdaF)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	assign op      = iox_op_type'(writedata[OP_LSB+1:OP_LSB]);
	assign cmdTake = write && (address == CSR_CMD) && (state_q == M_IDLE);

	// A command write stalls while a step runs; reads take one wait cycle.
	assign waitrequest = (write && address == CSR_CMD && state_q != M_IDLE) ||
		(read && !rdValid_q);

	// Read data is registered; unmapped addresses read zero.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdValid_q <= 1'b0;
			readdata  <= 32'h0;
		end else begin
			rdValid_q <= read && !rdValid_q;
			if (read && !rdValid_q) begin
				readdata <= (address == CSR_STAT) ?
					{16'h0, rxByte_q, 6'h0, nack_q, state_q != M_IDLE} : 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link sequencer: each bit takes four quarter periods of the serial clock.

	assign tick = (qCnt_q == 16'(QTR - 1));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= M_IDLE;
			qCnt_q    <= 16'h0;
			phase_q   <= 2'h0;
			bitCnt_q  <= 4'h0;
			tx_q      <= 9'h1FF;
			rx_q      <= 9'h0;
			sclHigh_q <= 1'b1;
			sdaHigh_q <= 1'b1;
			rxByte_q  <= 8'h00;
			nack_q    <= 1'b0;
		end else if (state_q == M_IDLE) begin
			qCnt_q   <= 16'h0;
			phase_q  <= 2'h0;
			bitCnt_q <= 4'h0;
			if (cmdTake) begin
				case (op)
					OP_START: state_q <= M_START;
					OP_WRITE: begin
						state_q <= M_BITS;
						tx_q    <= {writedata[7:0], 1'b1};
					end
					OP_READ: begin
						state_q <= M_BITS;
						tx_q    <= {8'hFF, !writedata[ACK_BIT]};
					end
					default: state_q <= M_STOP;
				endcase
			end
		end else begin
			qCnt_q <= tick ? 16'h0 : qCnt_q + 16'h1;
			if (tick) begin
				phase_q <= phase_q + 2'h1;
				case (state_q)
					M_START: begin
						case (phase_q)
							2'h0: sdaHigh_q <= 1'b1;
							2'h1: sclHigh_q <= 1'b1;
							2'h2: sdaHigh_q <= 1'b0;
							default: begin
								sclHigh_q <= 1'b0;
								state_q   <= M_IDLE;
							end
						endcase
					end
					M_STOP: begin
						case (phase_q)
							2'h0: sdaHigh_q <= 1'b0;
							2'h1: sclHigh_q <= 1'b1;
							2'h2: sdaHigh_q <= 1'b1;
							default: state_q <= M_IDLE;
						endcase
					end
					default: begin
						case (phase_q)
							2'h0: sdaHigh_q <= tx_q[8];
							2'h1: sclHigh_q <= 1'b1;
							2'h2: rx_q <= {rx_q[7:0], sdaF};
							default: begin
								sclHigh_q <= 1'b0;
								tx_q      <= {tx_q[7:0], 1'b1};
								bitCnt_q  <= bitCnt_q + 4'h1;
								if (bitCnt_q == 4'h8) begin
									state_q  <= M_IDLE;
									rxByte_q <= rx_q[8:1];
									nack_q   <= rx_q[0];
								end
							end
						endcase
					end
				endcase
			end
		end
	end

	// Open drain: lines are only ever pulled low.
	assign bus.mstSclOut = 1'b0;
	assign bus.mstSclOe  = !sclHigh_q;
	assign bus.mstSdaOut = 1'b0;
	assign bus.mstSdaOe  = !sdaHigh_q;
endmodule

// ---- tb/iox_properties.sv ----
// Concurrent checks on the two-wire link between the master and the expander.
// Assumes the signals of one iox_if and the system clock shared by both ends.
`timescale 1ns/1ps
module iox_properties
	import iox_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic mstSclOut,
	input wire logic mstSclOe,
	input wire logic mstSdaOut,
	input wire logic mstSdaOe,
	input wire logic devSdaOut,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	logic       sclQ;
	logic       sdaQ;
	logic       addrQ;
	logic       matchQ;
	logic       rwQ;
	logic       nackQ;
	logic       stopQ;
	logic [3:0] bitQ;
	logic [7:0] shiftQ;
	logic       rise;
	logic       start;
	logic       stop;
	logic       ackRise;
	logic       hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Edges and conditions seen on the resolved wires.
	assign rise    = scl && !sclQ;
	assign start   = scl && sclQ && sdaQ && !sda;
	assign stop    = scl && sclQ && !sdaQ && sda;
	assign ackRise = rise && (bitQ == 4'h8);
	assign hit     = (shiftQ[7:1] == SLAVE_ADDR);

	// Bit position and context; a START always reopens the address phase.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclQ   <= 1'b1;
			sdaQ   <= 1'b1;
			bitQ   <= 4'h0;
			shiftQ <= 8'h00;
			addrQ  <= 1'b0;
			matchQ <= 1'b0;
			rwQ    <= 1'b0;
			nackQ  <= 1'b0;
			stopQ  <= 1'b1;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			if (start) begin
				bitQ  <= 4'h0;
				addrQ <= 1'b1;
				nackQ <= 1'b0;
				stopQ <= 1'b0;
			end else if (stop) begin
				stopQ <= 1'b1;
			end else if (ackRise) begin
				bitQ  <= 4'h0;
				addrQ <= 1'b0;
				if (addrQ) begin
					matchQ <= hit;
					rwQ    <= shiftQ[0];
				end
				if (!addrQ && matchQ && rwQ && sda) begin
					nackQ <= 1'b1;
				end
			end else if (rise) begin
				bitQ   <= bitQ + 4'h1;
				shiftQ <= {shiftQ[6:0], sda};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// The acknowledge must hold low well into the high phase, not just at the edge.
	sequence ackHeld;
		(devSdaOe && !sda) [*8];
	endsequence

	a_addr_ack: assert property (ackRise && addrQ && hit |-> ackHeld)
		else $error("matching address not acknowledged");
	a_addr_ignore: assert property (ackRise && addrQ && !hit |-> !devSdaOe)
		else $error("foreign address acknowledged");
	a_rx_ack: assert property (ackRise && !addrQ && matchQ && !rwQ |-> ackHeld)
		else $error("received byte not acknowledged");
	a_tx_release: assert property (ackRise && !addrQ && matchQ && rwQ |-> !devSdaOe)
		else $error("data line held during master acknowledge");
	a_nack_quiet: assert property (nackQ |-> !devSdaOe)
		else $error("data line driven after missing acknowledge");
	a_stop_idle: assert property (stopQ |-> !devSdaOe)
		else $error("data line driven after stop");
	a_edge_low: assert property ($changed(devSdaOe) |-> !scl)
		else $error("slave data changed while clock high");
	a_high_stable: assert property (rise |-> ($stable(devSdaOe)) [*8])
		else $error("slave data unstable in clock high phase");
endmodule

// ---- tb/i2c_four_bit_io_expander_tb.sv ----
// Self-checking bench: software drives the master, which talks to the expander.
// Assumes QTR of 8 so one serial bit lasts 32 clocks; pins are modelled here.
`timescale 1ns/1ps
module i2c_four_bit_io_expander_tb
	import iox_pkg::*;
;
	logic        clk;
	logic        reset_n;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [3:0]  portPinIn;
	logic [3:0]  portPinOut;
	logic [3:0]  portPinOe;
	logic [3:0]  extPins;
	logic [7:0]  outM;
	logic [7:0]  invM;
	logic [7:0]  cfgM;
	logic [31:0] lastRd;
	logic [19:0] ent;
	logic [19:0] expQ[$];
	logic        cmpArm;
	int          nMismatch;
	int          samplesChecked;

	iox_if bus();

	iox_master #(.QTR(8)) u_iox_master (.clk(clk), .reset_n(reset_n), .bus(bus.master),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest));
	iox_expander u_iox_expander (.clk(clk), .reset_n(reset_n), .bus(bus.device),
		.portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));
	iox_properties u_iox_properties (.clk(clk), .reset_n(reset_n),
		.mstSclOut(bus.mstSclOut), .mstSclOe(bus.mstSclOe), .mstSdaOut(bus.mstSdaOut),
		.mstSdaOe(bus.mstSdaOe), .devSdaOut(bus.devSdaOut), .devSdaOe(bus.devSdaOe),
		.scl(bus.scl), .sda(bus.sda));

	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// A driven pin shows the expander's level, an undriven one the outside level.
	always_ff @(posedge clk) begin
		portPinIn <= (portPinOe & portPinOut) | (~portPinOe & extPins);
	end

	task stopTest;
		if (nMismatch == 0 && samplesChecked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input logic [9:0] msk);
		samplesChecked++;
		if (((got ^ exp) & msk) !== 10'h000) begin
			nMismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected register contents; the input register mirrors the pin model.
	function automatic logic [7:0] regM(input logic [1:0] s);
		case (s)
			SEL_INPUT:  return {INPUT_UPPER,
				((~cfgM[3:0] & outM[3:0]) | (cfgM[3:0] & extPins)) ^ invM[3:0]};
			SEL_OUTPUT: return outM;
			SEL_INVERT: return invM;
			default:    return cfgM;
		endcase
	endfunction

	// One Avalon transfer, held until waitrequest is seen low at a rising edge.
	// No cycle limit here: only the watchdog may end a wait that never finishes.
	task xfer(input logic [3:0] a, input logic wr, input logic [31:0] d);
		address   <= a;
		write     <= wr;
		read      <= !wr;
		writedata <= d;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		lastRd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask

	task op(input iox_op_type o, input logic [7:0] b, input logic ack);
		xfer(CSR_CMD, 1'b1, {21'h0, ack, o, b});
	endtask

	// Poll until idle, then note the expectation and make one armed status read.
	task waitCheck(input logic [9:0] exp, input logic [9:0] msk);
		do begin
			xfer(CSR_STAT, 1'b0, 32'h0);
		end while (lastRd[BUSY_BIT] !== 1'b0);
		expQ.push_back({msk, exp});
		cmpArm <= 1'b1;
		xfer(CSR_STAT, 1'b0, 32'h0);
		cmpArm <= 1'b0;
	endtask

	task sendAddr(input logic rw, input logic [6:0] a);
		op(OP_START, 8'h00, 1'b0);
		op(OP_WRITE, {a, rw}, 1'b0);
		waitCheck({8'h00, a != SLAVE_ADDR, 1'b0}, 10'h003);
	endtask

	task selReg(input logic [1:0] s);
		sendAddr(1'b0, SLAVE_ADDR);
		op(OP_WRITE, {6'h00, s}, 1'b0);
	endtask

	task wrReg(input logic [1:0] s, input logic [7:0] v);
		selReg(s);
		op(OP_WRITE, v, 1'b0);
		waitCheck(10'h000, 10'h003);
		op(OP_STOP, 8'h00, 1'b0);
	endtask

	// Read n bytes of the selected register, leaving the last one unacknowledged.
	task rdReg(input int n, input logic [7:0] v);
		sendAddr(1'b1, SLAVE_ADDR);
		for (int i = 0; i < n; i++) begin
			op(OP_READ, 8'h00, i < n - 1);
			waitCheck({v, i == n - 1, 1'b0}, 10'h3FF);
		end
		op(OP_STOP, 8'h00, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Compares each armed status read against the oldest noted expectation.
	always @(posedge clk) begin
		if (read && !waitrequest && cmpArm) begin
			ent = expQ.pop_front();
			chk({readdata[15:8], readdata[NACK_BIT], readdata[BUSY_BIT]}, ent[9:0], ent[19:10]);
		end
	end

	// Cuts a hang short at 80k clocks, well past the expected run of about 38k clocks.
	initial begin
		#640000;
		nMismatch++;
		stopTest;
	end

	// Main sequence.
	initial begin
		reset_n        = 1'b0;
		address        = 4'h0;
		read           = 1'b0;
		write          = 1'b0;
		writedata      = 32'h0;
		cmpArm         = 1'b0;
		nMismatch      = 0;
		samplesChecked = 0;
		void'($urandom(65868));
		extPins        = 4'($urandom);
		outM           = OUTPUT_RST;
		invM           = INVERT_RST;
		cfgM           = CONFIG_RST;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk({6'h0, portPinOe}, 10'h000, 10'h3FF);
		chk({6'h0, portPinOut}, 10'h00F, 10'h3FF);
		rdReg(1, regM(SEL_INPUT));
		for (int s = 1; s < 4; s++) begin
			selReg(2'(s));
			rdReg(1, regM(2'(s)));
		end
		repeat (3) begin
			outM    = 8'($urandom);
			cfgM    = 8'($urandom);
			invM    = 8'($urandom);
			extPins <= 4'($urandom);
			wrReg(SEL_OUTPUT, outM);
			wrReg(SEL_CONFIG, cfgM);
			wrReg(SEL_INVERT, invM);
			wrReg(SEL_INPUT, 8'($urandom));
			repeat (8) @(posedge clk);
			chk({6'h0, portPinOut}, {6'h0, outM[3:0]}, 10'h3FF);
			chk({6'h0, portPinOe}, {6'h0, ~cfgM[3:0]}, 10'h3FF);
			for (int s = 0; s < 4; s++) begin
				selReg(2'(s));
				rdReg(2, regM(2'(s)));
			end
			rdReg(1, regM(SEL_CONFIG));
		end
		sendAddr(1'b0, 7'h42);
		op(OP_STOP, 8'h00, 1'b0);
		rdReg(1, regM(SEL_CONFIG));
		stopTest;
	end
endmodule
